// ==== uin_top.v ====
// Top of the UART line-encoding block: Wishbone register slave, baud
// tick generator, receive register, address interrupt and the framers.
// Assumes a classic Wishbone master on core_clk and an asynchronous rx pin.
//
// Chosen here: register access over Wishbone and the address map.
`timescale 1ns/1ps
`include "uin_map.vh"

module uin_top (
  input wire core_clk,
  input wire rst,
  input wire wb_cyc,
  input wire wb_stb,
  input wire wb_we,
  input wire [7:0] wb_adr,
  input wire [3:0] wb_sel,
  input wire [31:0] wb_dat_w,
  output reg [31:0] wb_dat_r,
  output reg wb_ack,
  input wire rx_pin,
  output wire tx_pin,
  output reg irq_q
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  reg rx_meta_q;
  reg rx_sync_q;
  reg [2:0] cfg_q;
  reg [15:0] div_q;
  reg [15:0] bcnt_q;
  reg tick_q;
  reg [3:0] stat_q;
  reg [3:0] stat_d;
  reg [3:0] mask_q;
  reg [7:0] rbuf_q;
  reg pflag_q;
  reg rfull_q;
  reg ferr_q;
  reg tx_start_q;
  reg [7:0] tx_data_q;
  reg tx_ninth_q;
  reg [3:0] ev_set;
  reg [31:0] rd_mux;
  wire req;
  wire wr;
  wire rd;
  wire ir;
  wire pe;
  wire tx_busy;
  wire tx_done;
  wire rx_done;
  wire [7:0] rx_data;
  wire rx_ninth;
  wire rx_ferr;

  // Address decode used by both the write and the read paths.
  function hit;
    input [7:0] adr;
    input [7:0] ofs;
    begin
      hit = (adr == ofs);
    end
  endfunction

  assign req = wb_cyc & wb_stb & ~wb_ack;
  assign wr = req & wb_we;
  assign rd = req & ~wb_we;
  assign ir = cfg_q[`UIN_CFG_IR];
  assign pe = cfg_q[`UIN_CFG_PE];

  // ****************************************************************
  // Receive pin synchroniser
  // ****************************************************************
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rx_meta_q <= 1'b1;
      rx_sync_q <= 1'b1;
    end else begin
      rx_meta_q <= rx_pin;
      rx_sync_q <= rx_meta_q;
    end
  end

  // ****************************************************************
  // Baud tick at sixteen times the bit rate
  // ****************************************************************
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      bcnt_q <= 16'h0000;
      tick_q <= 1'b0;
    end else begin
      tick_q <= (bcnt_q >= div_q);
      if (bcnt_q >= div_q) begin
        bcnt_q <= 16'h0000;
      end else begin
        bcnt_q <= bcnt_q + 16'h0001;
      end
    end
  end

  // ****************************************************************
  // Framers
  // ****************************************************************
  uin_tx u_tx (
    .core_clk(core_clk),
    .rst(rst),
    .tick(tick_q),
    .start(tx_start_q),
    .data(tx_data_q),
    .ninth(tx_ninth_q),
    .pe(pe),
    .ir(ir),
    .tx_q(tx_pin),
    .busy(tx_busy),
    .done_q(tx_done)
  );

  uin_rx u_rx (
    .core_clk(core_clk),
    .rst(rst),
    .tick(tick_q),
    .rxd(rx_sync_q),
    .ir(ir),
    .pe(pe),
    .div(div_q),
    .done_q(rx_done),
    .data_q(rx_data),
    .ninth_q(rx_ninth),
    .ferr_q(rx_ferr)
  );

  // ****************************************************************
  // Configuration registers and transmit request
  // ****************************************************************
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cfg_q <= `UIN_CFG_RST;
      div_q <= `UIN_BAUD_DIV_RST;
      mask_q <= `UIN_MASK_RST;
      tx_start_q <= 1'b0;
      tx_data_q <= 8'h00;
      tx_ninth_q <= 1'b0;
    end else begin
      tx_start_q <= 1'b0;
      if (wr && wb_sel[0]) begin
        if (hit(wb_adr, `UIN_OFS_CFG)) cfg_q <= wb_dat_w[2:0];
        if (hit(wb_adr, `UIN_OFS_MASK)) mask_q <= wb_dat_w[3:0];
        if (hit(wb_adr, `UIN_OFS_BAUD)) div_q[7:0] <= wb_dat_w[7:0];
        // A write while a frame is on the line is dropped.
        if (hit(wb_adr, `UIN_OFS_DATA) && !tx_busy && !tx_start_q) begin
          tx_data_q <= wb_dat_w[7:0];
          tx_ninth_q <= wb_dat_w[`UIN_DATA_NINTH] & wb_sel[1];
          tx_start_q <= 1'b1;
        end
      end
      if (wr && wb_sel[1] && hit(wb_adr, `UIN_OFS_BAUD)) begin
        div_q[15:8] <= wb_dat_w[15:8];
      end
    end
  end

  // ****************************************************************
  // Receive register
  // ****************************************************************
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rbuf_q <= 8'h00;
      pflag_q <= 1'b0;
      rfull_q <= 1'b0;
      ferr_q <= 1'b0;
    end else begin
      if (rx_done) begin
        rbuf_q <= rx_data;
        pflag_q <= pe & rx_ninth;
        ferr_q <= rx_ferr;
        rfull_q <= 1'b1;
      end else if (rd && hit(wb_adr, `UIN_OFS_DATA)) begin
        rfull_q <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Event status and interrupt
  // ****************************************************************
  always @* begin
    ev_set = 4'h0;
    ev_set[`UIN_EV_RX] = rx_done;
    // Address event is taken from the character entering the receive register.
    ev_set[`UIN_EV_ADDR] = rx_done & pe & rx_ninth;
    ev_set[`UIN_EV_FERR] = rx_done & rx_ferr;
    ev_set[`UIN_EV_TX] = tx_done;
    stat_d = stat_q;
    if (rd && hit(wb_adr, `UIN_OFS_STAT)) begin
      stat_d = 4'h0;
    end
    // A new event in the clearing cycle is kept.
    stat_d = stat_d | ev_set;
  end

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      stat_q <= 4'h0;
      irq_q <= 1'b0;
    end else begin
      stat_q <= stat_d;
      irq_q <= |(stat_d & mask_q);
    end
  end

  // ****************************************************************
  // Wishbone read and acknowledge
  // ****************************************************************
  always @* begin
    rd_mux = 32'h00000000;
    case (wb_adr)
      `UIN_OFS_DATA: rd_mux = {23'h000000, pflag_q, rbuf_q};
      `UIN_OFS_CFG: rd_mux = {29'h00000000, cfg_q};
      `UIN_OFS_BAUD: rd_mux = {16'h0000, div_q};
      `UIN_OFS_STAT: rd_mux = {28'h0000000, stat_q};
      `UIN_OFS_MASK: rd_mux = {28'h0000000, mask_q};
      `UIN_OFS_LIVE: begin
        rd_mux[`UIN_LIVE_RXFULL] = rfull_q;
        rd_mux[`UIN_LIVE_PFLAG] = pflag_q;
        rd_mux[`UIN_LIVE_TXBUSY] = tx_busy | tx_start_q;
        rd_mux[`UIN_LIVE_FERR] = ferr_q;
      end
      default: rd_mux = 32'h00000000;
    endcase
  end

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wb_ack <= 1'b0;
      wb_dat_r <= 32'h00000000;
    end else begin
      wb_ack <= req;
      if (rd) begin
        wb_dat_r <= rd_mux;
      end
    end
  end

endmodule // uin_top

// ==== uin_map.vh ====
// Register map, field positions, reset values and timing counts of the UART
// line-encoding block. Included by every design file of the block.
`ifndef UIN_MAP_VH
`define UIN_MAP_VH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define UIN_OFS_DATA 8'h00
`define UIN_OFS_CFG 8'h04
`define UIN_OFS_BAUD 8'h08
`define UIN_OFS_STAT 8'h0C
`define UIN_OFS_MASK 8'h10
`define UIN_OFS_LIVE 8'h14

// ****************************************************************
// Field positions
// ****************************************************************
`define UIN_CFG_IR 0
`define UIN_CFG_PE 1
`define UIN_CFG_FDIS 2
`define UIN_DATA_NINTH 8
`define UIN_EV_RX 0
`define UIN_EV_ADDR 1
`define UIN_EV_FERR 2
`define UIN_EV_TX 3
`define UIN_LIVE_RXFULL 0
`define UIN_LIVE_PFLAG 1
`define UIN_LIVE_TXBUSY 2
`define UIN_LIVE_FERR 3

// ****************************************************************
// Reset values
// ****************************************************************
`define UIN_CFG_RST 3'h0
`define UIN_MASK_RST 4'h0
`define UIN_BAUD_DIV_RST 16'h006B

// ****************************************************************
// Timing counts in oversampling ticks, and the index of the last data bit
// ****************************************************************
`define UIN_TICK_LAST 4'hF
`define UIN_IR_PULSE_TICKS 4'h3
`define UIN_MAJ_A 4'h7
`define UIN_MAJ_B 4'h8
`define UIN_SAMPLE_TICK 4'h9
`define UIN_IR_ALIGN_TICK 4'h1
`define UIN_LAST_DATA_BIT 3'h7

`endif

// ==== uin_tx.v ====
// Transmit framer: start, eight data bits, optional ninth bit, one stop bit.
// Assumes a one-cycle tick at sixteen times the baud rate.
`timescale 1ns/1ps
`include "uin_map.vh"

module uin_tx (
  input wire core_clk,
  input wire rst,
  input wire tick,
  input wire start,
  input wire [7:0] data,
  input wire ninth,
  input wire pe,
  input wire ir,
  output reg tx_q,
  output wire busy,
  output reg done_q
);

  localparam [2:0] ST_IDLE = 3'd0;
  localparam [2:0] ST_START = 3'd1;
  localparam [2:0] ST_DATA = 3'd2;
  localparam [2:0] ST_PAR = 3'd3;
  localparam [2:0] ST_STOP = 3'd4;

  reg [2:0] state_q;
  reg [3:0] ph_q;
  reg [2:0] bit_q;
  reg [7:0] sh_q;
  reg ninth_q;
  reg pend_q;
  reg line_bit;

  assign busy = (state_q != ST_IDLE) | pend_q;

  always @* begin
    case (state_q)
      ST_START: line_bit = 1'b0;
      ST_DATA: line_bit = sh_q[0];
      ST_PAR: line_bit = ninth_q;
      default: line_bit = 1'b1;
    endcase
  end

  // ****************************************************************
  // Frame sequencer
  // ****************************************************************
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_q <= ST_IDLE;
      ph_q <= 4'h0;
      bit_q <= 3'h0;
      sh_q <= 8'h00;
      ninth_q <= 1'b0;
      pend_q <= 1'b0;
      tx_q <= 1'b1;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      // A zero bit in infrared mode is a low pulse of three ticks only.
      tx_q <= ir ? (line_bit | (ph_q >= `UIN_IR_PULSE_TICKS)) : line_bit;
      if (state_q == ST_IDLE) begin
        ph_q <= 4'h0;
        if (start) begin
          sh_q <= data;
          ninth_q <= ninth;
          bit_q <= 3'h0;
        end
        // The frame waits for a tick so that every bit spans whole ticks.
        if ((start | pend_q) && tick) begin
          state_q <= ST_START;
          pend_q <= 1'b0;
        end else if (start) begin
          pend_q <= 1'b1;
        end
      end else if (tick) begin
        ph_q <= ph_q + 4'h1;
        if (ph_q == `UIN_TICK_LAST) begin
          case (state_q)
            ST_START: state_q <= ST_DATA;
            ST_DATA: begin
              sh_q <= {1'b0, sh_q[7:1]};
              bit_q <= bit_q + 3'h1;
              if (bit_q == `UIN_LAST_DATA_BIT) begin
                state_q <= pe ? ST_PAR : ST_STOP;
              end
            end
            ST_PAR: state_q <= ST_STOP;
            default: begin
              state_q <= ST_IDLE;
              done_q <= 1'b1;
            end
          endcase
        end
      end
    end
  end

endmodule // uin_tx

// ==== uin_rx.v ====
// Receive deframer for normal and infrared line coding.
// Assumes rxd is already synchronised to core_clk and a sixteen-times tick.
`timescale 1ns/1ps
`include "uin_map.vh"

module uin_rx (
  input wire core_clk,
  input wire rst,
  input wire tick,
  input wire rxd,
  input wire ir,
  input wire pe,
  input wire [15:0] div,
  output reg done_q,
  output reg [7:0] data_q,
  output reg ninth_q,
  output reg ferr_q
);

  localparam [2:0] ST_IDLE = 3'd0;
  localparam [2:0] ST_START = 3'd1;
  localparam [2:0] ST_DATA = 3'd2;
  localparam [2:0] ST_PAR = 3'd3;
  localparam [2:0] ST_STOP = 3'd4;

  reg [2:0] state_q;
  reg [3:0] ph_q;
  reg [2:0] bit_q;
  reg [15:0] hi_run_q;
  reg seen_q;
  reg pok_q;
  reg m0_q;
  reg m1_q;
  wire pulse_ok;
  wire sample;
  wire bit_val;

  function maj3;
    input a;
    input b;
    input c;
    begin
      maj3 = (a & b) | (a & c) | (b & c);
    end
  endfunction

  // A high level counts as an infrared pulse only after one full tick.
  assign pulse_ok = rxd && (hi_run_q >= div);
  assign sample = tick && (ph_q == `UIN_SAMPLE_TICK);
  assign bit_val = ir ? ~(seen_q | (pulse_ok & ~pok_q)) : maj3(m0_q, m1_q, rxd);

  // ****************************************************************
  // Deframer
  // ****************************************************************
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_q <= ST_IDLE;
      ph_q <= 4'h0;
      bit_q <= 3'h0;
      hi_run_q <= 16'h0000;
      seen_q <= 1'b0;
      pok_q <= 1'b0;
      m0_q <= 1'b1;
      m1_q <= 1'b1;
      done_q <= 1'b0;
      data_q <= 8'h00;
      ninth_q <= 1'b0;
      ferr_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (!rxd) begin
        hi_run_q <= 16'h0000;
      end else if (hi_run_q != 16'hFFFF) begin
        hi_run_q <= hi_run_q + 16'h0001;
      end
      if (tick) begin
        ph_q <= ph_q + 4'h1;
        if (ph_q == `UIN_MAJ_A) m0_q <= rxd;
        if (ph_q == `UIN_MAJ_B) m1_q <= rxd;
      end
      // Each pulse counts once, so the tail of one pulse cannot leak into the next slot.
      pok_q <= pulse_ok;
      if (sample) begin
        seen_q <= 1'b0;
      end else if (pulse_ok && !pok_q) begin
        seen_q <= 1'b1;
      end
      case (state_q)
        ST_IDLE: begin
          bit_q <= 3'h0;
          if (ir && pulse_ok) begin
            // Start pulse confirmed; a skip sample mid start slot keeps every later sample mid slot.
            state_q <= ST_START;
            ph_q <= `UIN_IR_ALIGN_TICK;
            seen_q <= 1'b0;
          end else if (!ir && !rxd) begin
            state_q <= ST_START;
            ph_q <= 4'h0;
          end
        end
        ST_START: begin
          if (sample) state_q <= (bit_val && !ir) ? ST_IDLE : ST_DATA;
        end
        ST_DATA: begin
          if (sample) begin
            data_q <= {bit_val, data_q[7:1]};
            bit_q <= bit_q + 3'h1;
            if (bit_q == `UIN_LAST_DATA_BIT) state_q <= pe ? ST_PAR : ST_STOP;
          end
        end
        ST_PAR: begin
          if (sample) begin
            ninth_q <= bit_val;
            state_q <= ST_STOP;
          end
        end
        ST_STOP: begin
          if (sample) begin
            if (!pe) ninth_q <= 1'b0;
            ferr_q <= ~bit_val;
            done_q <= 1'b1;
            state_q <= ST_IDLE;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

endmodule // uin_rx

// ==== uin_top_properties.sv ====
// Checker for the line-encoding block: bus answer timing, readback and pulse widths.
// Sees only the top ports; shadows CFG, MASK and BAUD from the bus writes it sees.
`timescale 1ns/1ps
module uin_chk (
  input wire core_clk,
  input wire rst,
  input wire wb_cyc,
  input wire wb_stb,
  input wire wb_we,
  input wire [7:0] wb_adr,
  input wire [3:0] wb_sel,
  input wire [31:0] wb_dat_w,
  input wire [31:0] wb_dat_r,
  input wire wb_ack,
  input wire rx_pin,
  input wire tx_pin,
  input wire irq_q
);
  reg [2:0] cfg_q;
  reg [3:0] mask_q;
  reg [15:0] div_q;
  reg [15:0] low_q;
  wire wr = wb_cyc & wb_stb & wb_we & ~wb_ack & wb_sel[0];
  wire rd = wb_ack & ~wb_we;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cfg_q <= 3'h0;
      mask_q <= 4'h0;
      div_q <= 16'h006B;
      low_q <= 16'h0000;
    end else begin
      low_q <= tx_pin ? 16'h0000 : low_q + 16'h0001;
      if (wr && wb_adr == 8'h04) cfg_q <= wb_dat_w[2:0];
      if (wr && wb_adr == 8'h10) mask_q <= wb_dat_w[3:0];
      if (wr && wb_adr == 8'h08) div_q <= wb_dat_w[15:0];
    end
  end
  property p_ack_next;
    wb_cyc && wb_stb && !wb_ack |=> wb_ack;
  endproperty
  a_ack_next: assert property (p_ack_next) else $error("ack missing after request");
  property p_ack_one;
    wb_ack |=> !wb_ack;
  endproperty
  a_ack_one: assert property (p_ack_one) else $error("ack longer than one cycle");
  property p_unmapped;
    rd && !(wb_adr inside {8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14}) |-> wb_dat_r == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_cfg_rd;
    rd && wb_adr == 8'h04 |-> wb_dat_r == {29'h0, cfg_q};
  endproperty
  a_cfg_rd: assert property (p_cfg_rd) else $error("config readback wrong");
  property p_mask_rd;
    rd && wb_adr == 8'h10 |-> wb_dat_r == {28'h0, mask_q};
  endproperty
  a_mask_rd: assert property (p_mask_rd) else $error("mask readback wrong");
  property p_irq_masked;
    mask_q == 4'h0 |=> !irq_q;
  endproperty
  a_irq_masked: assert property (p_irq_masked) else $error("irq with all masked");
  property p_ir_pulse;
    $rose(tx_pin) && cfg_q[0] |-> low_q == 16'h0003 * (div_q + 16'h0001);
  endproperty
  a_ir_pulse: assert property (p_ir_pulse) else $error("infrared pulse width wrong");
  property p_nrz_run;
    $rose(tx_pin) && !cfg_q[0] |-> low_q % (16'h0010 * (div_q + 16'h0001)) == 16'h0000;
  endproperty
  a_nrz_run: assert property (p_nrz_run) else $error("plain low run not whole bits");
  property p_pflag;
    rd && wb_adr == 8'h00 && !cfg_q[1] |-> !wb_dat_r[8];
  endproperty
  a_pflag: assert property (p_pflag) else $error("parity flag without parity");
endmodule // uin_chk

bind uin_top uin_chk i_chk (.core_clk(core_clk), .rst(rst), .wb_cyc(wb_cyc),
  .wb_stb(wb_stb), .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel), .wb_dat_w(wb_dat_w),
  .wb_dat_r(wb_dat_r), .wb_ack(wb_ack), .rx_pin(rx_pin), .tx_pin(tx_pin), .irq_q(irq_q));

// ==== uin_line_model.sv ====
// Far-side line model: sends normal or infrared frames on rx_pin, reads tx_pin.
// Assumes a bit of 64 core clocks, that is BAUD set to 3.
`timescale 1ns/1ps
module uin_line_model (
  input wire core_clk,
  input wire tx_pin,
  output reg rx_pin
);
  localparam int BIT = 64;
  initial rx_pin = 1'b1;
  task automatic idle(input ir);
    @(posedge core_clk);
    rx_pin <= ~ir;
  endtask
  task automatic pulse(input integer w);
    @(posedge core_clk);
    rx_pin <= 1'b1;
    repeat (w) @(posedge core_clk);
    rx_pin <= 1'b0;
  endtask
  // Start, eight data bits LSB first, ninth bit or a spare stop, then stop.
  task automatic send(input [8:0] d, input nine, input ir);
    reg [10:0] f;
    integer k;
    f = {1'b1, nine ? d[8] : 1'b1, d[7:0], 1'b0};
    for (k = 0; k < 11; k = k + 1) begin
      @(posedge core_clk);
      if (ir) begin
        rx_pin <= ~f[k];
        repeat (BIT * 3 / 16) @(posedge core_clk);
        rx_pin <= 1'b0;
        repeat (BIT - BIT * 3 / 16 - 1) @(posedge core_clk);
      end else begin
        rx_pin <= f[k];
        repeat (BIT - 1) @(posedge core_clk);
      end
    end
  endtask
  task automatic grab(input ir, output [9:0] v);
    integer k;
    v = 10'h3FF;
    for (k = 0; k < 4000 && tx_pin !== 1'b0; k = k + 1) @(posedge core_clk);
    if (tx_pin === 1'b0) begin
      for (k = 0; k < 10; k = k + 1) begin
        repeat (k == 0 ? (ir ? 2 : BIT / 2) : BIT) @(posedge core_clk);
        v[k] = tx_pin;
      end
    end
  endtask
endmodule // uin_line_model

// ==== tb_top.sv ====
// Bench for the line-encoding block: registers over Wishbone, frames on both pins,
// address interrupt and infrared coding. Assumes the line model on the pins.
`timescale 1ns/1ps
module tb_top;
  reg core_clk = 1'b0;
  reg rst = 1'b1;
  reg wb_cyc = 1'b0;
  reg wb_stb = 1'b0;
  reg wb_we = 1'b0;
  reg [7:0] wb_adr = 8'h00;
  reg [31:0] wb_dat_w = 32'h0;
  wire [31:0] wb_dat_r;
  wire wb_ack, rx_pin, tx_pin, irq_q;
  integer miscompares = 0;
  integer cmp_count = 0;
  integer i;
  reg [31:0] q;
  reg [9:0] v;
  uin_top i_dut (.core_clk(core_clk), .rst(rst), .wb_cyc(wb_cyc), .wb_stb(wb_stb),
    .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(4'hF), .wb_dat_w(wb_dat_w),
    .wb_dat_r(wb_dat_r), .wb_ack(wb_ack), .rx_pin(rx_pin), .tx_pin(tx_pin), .irq_q(irq_q));
  uin_line_model i_line (.core_clk(core_clk), .tx_pin(tx_pin), .rx_pin(rx_pin));
  initial begin
    forever #2.5 core_clk = ~core_clk;
  end
  // ****
  // Tasks
  // ****
  task automatic close_out;
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input [31:0] e, input [31:0] g);
    cmp_count = cmp_count + 1;
    if (g !== e) begin
      $display("unexpected %s exp %h got %h", nm, e, g);
      miscompares = miscompares + 1;
    end
  endtask
  task automatic wb(input we, input [7:0] a, input [31:0] d, output [31:0] r);
    integer n;
    n = 0;
    @(posedge core_clk);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= a;
    wb_dat_w <= d;
    @(posedge core_clk);
    while (wb_ack !== 1'b1 && n < 20) begin
      @(posedge core_clk);
      n = n + 1;
    end
    r = wb_dat_r;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    if (n == 20) begin
      chk("ack", 32'h1, 32'h0);
      close_out;
    end
  endtask
  task automatic rc(input string nm, input [7:0] a, input [31:0] e);
    wb(1'b0, a, 32'h0, q);
    chk(nm, e, q);
  endtask
  task automatic tx(input [8:0] d, input hi, input ir);
    wb(1'b1, 8'h00, {23'h0, d}, q);
    i_line.grab(ir, v);
    chk("frame", {22'h0, hi, d[7:0], 1'b0}, {22'h0, v});
    repeat (192) @(posedge core_clk);
  endtask
  task automatic flush(input [31:0] c, input ir);
    wb(1'b1, 8'h04, c, q);
    i_line.idle(ir);
    repeat (800) @(posedge core_clk);
    wb(1'b0, 8'h0C, 32'h0, q);
  endtask
  // ****
  // Sequence
  // ****
  initial begin
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
    rc("cfg", 8'h04, 32'h0);
    rc("mask", 8'h10, 32'h0);
    rc("baud", 8'h08, 32'h006B);
    wb(1'b1, 8'h18, 32'hFF, q);
    rc("unmapped", 8'h18, 32'h0);
    wb(1'b1, 8'h08, 32'h3, q);
    tx(9'h1A5, 1'b1, 1'b0);
    i_line.send(9'h13C, 1'b0, 1'b0);
    rc("data", 8'h00, 32'h03C);
    rc("stat", 8'h0C, 32'h9);
    flush(32'h1, 1'b1);
    i_line.pulse(2);
    repeat (800) @(posedge core_clk);
    rc("stat", 8'h0C, 32'h0);
    i_line.send(9'h0C3, 1'b0, 1'b1);
    rc("data", 8'h00, 32'h0C3);
    rc("stat", 8'h0C, 32'h1);
    tx(9'h055, 1'b1, 1'b1);
    flush(32'h6, 1'b0);
    rc("cfg", 8'h04, 32'h6);
    for (i = 0; i < 2; i = i + 1) tx({i[0], 8'h5A}, i[0], 1'b0);
    rc("stat", 8'h0C, 32'h8);
    wb(1'b1, 8'h10, 32'h2, q);
    i_line.send(9'h1A5, 1'b1, 1'b0);
    chk("irq", 32'h1, {31'h0, irq_q});
    rc("data", 8'h00, 32'h1A5);
    rc("live", 8'h14, 32'h2);
    rc("stat", 8'h0C, 32'h3);
    repeat (2) @(posedge core_clk);
    chk("irq", 32'h0, {31'h0, irq_q});
    i_line.send(9'h042, 1'b1, 1'b0);
    chk("irq", 32'h0, {31'h0, irq_q});
    rc("data", 8'h00, 32'h042);
    wb(1'b1, 8'h10, 32'h0, q);
    i_line.send(9'h1A5, 1'b1, 1'b0);
    chk("irq", 32'h0, {31'h0, irq_q});
    rc("stat", 8'h0C, 32'h3);
    close_out;
  end
endmodule // tb_top
